// ---- core/nv_if.sv ----
// Link between the controller and its settings store.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface nv_if;
	import run_ctl_pkg::*;
	logic      save;
	logic      erase;
	settings_s wr_image;
	settings_s rd_image;
	logic      rd_valid;
	modport ctl   (output save, erase, wr_image, input rd_image, rd_valid);
	modport store (input save, erase, wr_image, output rd_image, rd_valid);
endinterface
`default_nettype wire

// ---- core/operating_mode_run_control.sv ----
// Operating mode and run control: mode choice, settings save, run gating.
// Assumes an AXI4-Lite master, a datapath answering cycle_start with
// cycle_done, and run_stop_pin synchronous to aclk.
//
// Overview of operation
// R1 - Restore command or pin low at power-up selects factory-restore mode.
// R2 - Factory restore reloads every operating parameter with its default.
// R3 - Factory restore erases the saved settings image.
// R4 - Pin high at power-up or load command selects saved-settings mode.
// R5 - Saved-settings mode loads parameters from storage and runs on them.
// R6 - Save copies current state; a later load restores that copy, run taken from the pin if pin control is on.
// R7 - Without a run instruction no read-and-update cycles happen.
// R8 - After run, cycles repeat back to back until stop.
// R9 - Commands from bus and keypad keep executing while running.
// R10 - With pin control on, run while pin high, stop while pin low.
// R11 - Pin control off makes the pin level irrelevant to running.
// R12 - Host must not enable pin control with lap or count functions.
// R13 - Send with count n performs exactly n cycles, zero meaning one.
// R14 - After a send burst the prior run or stop state resumes.
// R15 - Commands arriving during a send burst wait until it completes.
// R16 - After run, a programmable delay precedes the first cycle.
// R17 - The start delay counts whole seconds, up to 255.
// R18 - Delay uses a one-second tick that restarts on each run request.
// R19 - With pin control on, a pin change overrides the last command.
`timescale 1ns/100ps
`default_nettype none
module operating_mode_run_control
	import run_ctl_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              nv_resetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [DATA_W-1:0] s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              run_stop_pin,
	input  wire logic              keypad_valid,
	input  wire logic [CMD_W-1:0]  keypad_cmd,
	output var  logic              cycle_start,
	input  wire logic              cycle_done,
	output var  logic              running,
	output var  logic              factory_mode,
	output var  logic [31:0]       param_out
);
	nv_if nv ();

	settings_s            cfg;
	settings_s            next_cfg;
	seq_state_e           state;
	logic                 next_factory;
	logic                 boot_done;
	logic                 pin_q;
	logic                 pin_edge;
	logic                 aw_held;
	logic                 w_held;
	logic [ADDR_W-1:0]    aw_addr_q;
	logic [DATA_W-1:0]    w_data_q;
	logic [3:0]           w_strb_q;
	logic                 wr_commit;
	logic [DATA_W-1:0]    wr_merged;
	logic [CMD_W-1:0]     cmd_now;
	logic [CMD_W-1:0]     pend;
	logic                 pend_valid;
	logic                 burst_busy;
	logic [CMD_W-1:0]     exec;
	logic                 do_restore;
	logic                 do_load;
	logic                 start_req;
	logic                 tick;
	logic                 delay_active;
	logic [7:0]           delay_left;
	logic [COUNT_W-1:0]   burst_left;
	logic [COUNT_W-1:0]   send_n;
	logic                 cycle_ok;
	logic [DATA_W-1:0]    status;

	// ==========================================================
	// Helpers
	function automatic logic known_reg(input logic [ADDR_W-1:0] a);
		return a == OFS_CMD || a == OFS_PARAM || a == OFS_DELAY ||
			a == OFS_STATUS;
	endfunction

	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Sub-blocks
	settings_store u_store (
		.aclk      (aclk),
		.nv_resetn (nv_resetn),
		.nv        (nv.store)
	);

	second_tick #(
		.TICK_CYCLES_P (TICK_CYCLES_P)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.restart (start_req),  // [R18]
		.tick    (tick)
	);

	// ==========================================================
	// AXI4-Lite write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_commit     = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr_q    <= '0;
			w_data_q     <= '0;
			w_strb_q     <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held   <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_commit) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known_reg(aw_addr_q) ? RESP_OKAY
					: RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel, one cycle to answer
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= known_reg(s_axi_araddr) ? RESP_OKAY
				: RESP_SLVERR;
			case (s_axi_araddr)
				OFS_PARAM:  s_axi_rdata <= cfg.param;
				OFS_DELAY:  s_axi_rdata <= {24'h000000, cfg.delay};
				OFS_STATUS: s_axi_rdata <= status;
				default:    s_axi_rdata <= '0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign status = {8'h00, delay_left, burst_left, state != SEQ_IDLE,
		pend_valid, burst_busy, delay_active, pin_q, cfg.pin_en,
		factory_mode, cfg.run};

	// ==========================================================
	// Command sources: bus command word and keypad, merged
	assign wr_merged = merge_bytes(32'h00000000, w_data_q, w_strb_q);
	assign cmd_now = ((wr_commit && aw_addr_q == OFS_CMD) ?
		wr_merged[CMD_W-1:0] : '0) |
		(keypad_valid ? keypad_cmd : '0);  // [R9]

	assign burst_busy = burst_left != '0;

	// Commands wait in a merged slot while a send burst is under way
	always_comb begin
		exec = '0;
		if (!burst_busy) begin
			exec = pend_valid ? pend : cmd_now;  // [R15]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend       <= '0;
			pend_valid <= 1'b0;
		end else if (!burst_busy && pend_valid) begin
			pend       <= cmd_now;  // [R15]
			pend_valid <= cmd_now[CMD_SEND:0] != '0;
		end else if (burst_busy && cmd_now[CMD_SEND:0] != '0) begin
			pend[CMD_SEND:0] <= pend[CMD_SEND:0] | cmd_now[CMD_SEND:0];
			if (cmd_now[CMD_SEND]) begin
				pend[CMD_W-1:CMD_COUNT_LSB] <=
					cmd_now[CMD_W-1:CMD_COUNT_LSB];
			end
			pend_valid <= 1'b1;  // [R15]
		end
	end

	// ==========================================================
	// Power-up strap capture and pin edge detection
	assign do_restore = (!boot_done && !run_stop_pin) ||
		exec[CMD_RESTORE];  // [R1]
	assign do_load = (!boot_done && run_stop_pin) || exec[CMD_LOAD];  // [R4]
	assign pin_edge = run_stop_pin != pin_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_done <= 1'b0;
			pin_q     <= 1'b1;
		end else begin
			boot_done <= 1'b1;
			pin_q     <= run_stop_pin;
		end
	end

	// ==========================================================
	// Next operating settings from writes, pin and commands
	always_comb begin
		next_cfg     = cfg;
		next_factory = factory_mode;
		start_req    = 1'b0;
		nv.save      = 1'b0;
		nv.erase     = 1'b0;
		nv.wr_image  = cfg;
		if (wr_commit && aw_addr_q == OFS_PARAM) begin
			next_cfg.param = merge_bytes(cfg.param, w_data_q, w_strb_q);
		end
		if (wr_commit && aw_addr_q == OFS_DELAY && w_strb_q[0]) begin
			next_cfg.delay = w_data_q[7:0];  // [R17]
		end
		if (cfg.pin_en && pin_edge) begin
			next_cfg.run = run_stop_pin;  // [R10] [R19]
			start_req    = run_stop_pin;
		end
		if (do_restore) begin
			next_cfg     = SETTINGS_DEFAULT;  // [R2]
			next_factory = 1'b1;
			nv.erase     = 1'b1;  // [R3]
		end else if (do_load) begin
			next_cfg = nv.rd_valid ? nv.rd_image : SETTINGS_DEFAULT;  // [R5]
			if (next_cfg.pin_en) begin
				next_cfg.run = run_stop_pin;
			end
			next_factory = 1'b0;
			start_req    = 1'b1;
		end else if (exec[CMD_SAVE]) begin
			nv.save = 1'b1;  // [R6]
		end
		if (exec[CMD_STOP]) begin
			next_cfg.run = 1'b0;  // [R8]
		end else if (exec[CMD_RUN]) begin
			next_cfg.run = 1'b1;  // [R8]
			start_req    = 1'b1;
		end
		if (exec[CMD_PIN_DIS]) begin
			next_cfg.pin_en = 1'b0;  // [R11]
		end else if (exec[CMD_PIN_EN]) begin
			next_cfg.pin_en = 1'b1;  // [R10]
			next_cfg.run    = run_stop_pin;
			start_req       = 1'b1;
		end
		start_req = start_req && next_cfg.run;  // [R18]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg          <= SETTINGS_DEFAULT;
			factory_mode <= 1'b0;
		end else begin
			cfg          <= next_cfg;
			factory_mode <= next_factory;
		end
	end

	assign running   = cfg.run;
	assign param_out = cfg.param;

	// ==========================================================
	// Start delay in whole seconds, restarted on every run request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			delay_active <= 1'b0;
			delay_left   <= 8'h00;
		end else if (start_req) begin
			delay_active <= 1'b1;  // [R16]
			delay_left   <= next_cfg.delay;
		end else if (!cfg.run || delay_left == 8'h00) begin
			delay_active <= 1'b0;
			delay_left   <= 8'h00;
		end else if (tick) begin
			delay_left <= delay_left - 1'b1;  // [R17]
		end
	end

	// ==========================================================
	// Counted send burst; zero count means one cycle
	assign send_n = (exec[CMD_W-1:CMD_COUNT_LSB] == '0) ? COUNT_W'(1)
		: exec[CMD_W-1:CMD_COUNT_LSB];  // [R13]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_left <= '0;
		end else if (exec[CMD_SEND]) begin
			burst_left <= send_n;  // [R13]
		end else if (state == SEQ_WAIT && cycle_done && burst_busy) begin
			burst_left <= burst_left - 1'b1;  // [R14]
		end
	end

	// ==========================================================
	// Cycle sequencer: burst cycles first, then continuous running
	assign cycle_ok    = burst_busy || (cfg.run && !delay_active);  // [R7]
	assign cycle_start = state == SEQ_ISSUE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= SEQ_IDLE;
		end else begin
			case (state)
				SEQ_IDLE:  state <= cycle_ok ? SEQ_ISSUE : SEQ_IDLE;  // [R8]
				SEQ_ISSUE: state <= SEQ_WAIT;
				SEQ_WAIT:  state <= cycle_done ? SEQ_IDLE : SEQ_WAIT;
				default:   state <= SEQ_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_BOOT_RESTORE: assert property ( // [R1]
		!boot_done && !run_stop_pin |=> factory_mode && !nv.rd_valid)
		else $error("power-up with pin low did not restore defaults");
	AST_RESTORE_DEFAULTS: assert property ( // [R2]
		exec[CMD_RESTORE] |=> cfg.param == PARAM_RESET &&
		cfg.delay == DELAY_RESET && !cfg.pin_en)
		else $error("restore left a non-default parameter");
	AST_RESTORE_ERASE: assert property ( // [R3]
		do_restore |=> !nv.rd_valid)
		else $error("restore did not erase the saved image");
	AST_LOAD_SAVED: assert property ( // [R5]
		do_load && !do_restore && nv.rd_valid |=>
		cfg.param == $past(nv.rd_image.param) && !factory_mode)
		else $error("load did not take the saved parameters");
	AST_SAVE_IMAGE: assert property ( // [R6]
		nv.save |=> nv.rd_valid && nv.rd_image == $past(cfg))
		else $error("save did not capture the current state");
	AST_IDLE_QUIET: assert property ( // [R7]
		state == SEQ_IDLE && !cfg.run && !burst_busy |=> !cycle_start)
		else $error("cycle started without a run instruction");
	AST_RUN_REPEAT: assert property ( // [R8]
		state == SEQ_WAIT && cycle_done && next_cfg.run && !delay_active &&
		!start_req |=> ##1 cycle_start)
		else $error("running did not start the next cycle");
	AST_PIN_FOLLOW: assert property ( // [R10]
		cfg.pin_en && pin_edge && exec == '0 && boot_done |=>
		cfg.run == $past(run_stop_pin))
		else $error("run state did not follow the pin");
	AST_PIN_IGNORED: assert property ( // [R11]
		!cfg.pin_en && exec == '0 && boot_done |=> $stable(cfg.run))
		else $error("pin changed run state while pin control off");
	AST_SEND_COUNT: assert property ( // [R13]
		exec[CMD_SEND] |=> burst_left == $past(send_n) && burst_busy)
		else $error("send loaded a wrong cycle count");
	AST_BURST_DEFER: assert property ( // [R15]
		burst_busy && cmd_now[CMD_SEND:0] != '0 |->
		exec == '0 ##1 pend_valid)
		else $error("command executed during a send burst");
	AST_DELAY_HOLD: assert property ( // [R16]
		start_req && next_cfg.delay != 8'h00 |=> delay_active [*3])
		else $error("start delay ended too early");
endmodule
`default_nettype wire

// ---- core/run_ctl_pkg.sv ----
// Constants and types shared by the run control block.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package run_ctl_pkg;
	// ==========================================================
	// Register map
	localparam int         ADDR_W     = 8;
	localparam int         DATA_W     = 32;
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_PARAM  = 8'h04;
	localparam logic [7:0] OFS_DELAY  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	// ==========================================================
	// Command word fields
	localparam int CMD_RESTORE   = 0;
	localparam int CMD_LOAD      = 1;
	localparam int CMD_SAVE      = 2;
	localparam int CMD_RUN       = 3;
	localparam int CMD_STOP      = 4;
	localparam int CMD_PIN_EN    = 5;
	localparam int CMD_PIN_DIS   = 6;
	localparam int CMD_SEND      = 7;
	localparam int CMD_COUNT_LSB = 8;
	localparam int CMD_W         = 16;
	localparam int COUNT_W       = 8;
	// ==========================================================
	// Status word fields
	localparam int STS_RUN       = 0;
	localparam int STS_FACTORY   = 1;
	localparam int STS_PIN_EN    = 2;
	localparam int STS_PIN       = 3;
	localparam int STS_DELAY     = 4;
	localparam int STS_BURST     = 5;
	localparam int STS_PEND      = 6;
	localparam int STS_BUSY      = 7;
	localparam int STS_LEFT_LSB  = 8;
	localparam int STS_DLEFT_LSB = 16;
	// ==========================================================
	// Reset values and responses
	localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
	localparam logic [7:0]  DELAY_RESET = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	// ==========================================================
	// Timing: one start-delay step in clock cycles
	localparam int CLK_FREQ_HZ   = 250_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES   = TICK_PERIOD_S * CLK_FREQ_HZ;
	// ==========================================================
	// Operating settings image and sequencer states
	typedef struct packed {
		logic [31:0] param;
		logic [7:0]  delay;
		logic        pin_en;
		logic        run;
	} settings_s;
	localparam settings_s SETTINGS_DEFAULT = '{param: PARAM_RESET,
		delay: DELAY_RESET, pin_en: 1'b0, run: 1'b0};
	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b001,
		SEQ_ISSUE = 3'b010,
		SEQ_WAIT  = 3'b100
	} seq_state_e;
endpackage

// ---- core/second_tick.sv ----
// One-second tick generator for the start delay.
// Assumes restart is a one-cycle pulse from the controller.
`timescale 1ns/100ps
`default_nettype none
module second_tick
	import run_ctl_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic restart,
	output var  logic tick
);
	localparam int CNT_W = $clog2(TICK_CYCLES_P);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES_P - 1);

	logic [CNT_W-1:0] count;

	// ==========================================================
	// Elaboration check
	if (TICK_CYCLES_P < 2) begin : g_bad_tick
		$error("second_tick needs at least two cycles per tick");
	end

	// ==========================================================
	// Cycle counter, restarted so the first step is a full second
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick  <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- core/settings_store.sv ----
// Non-volatile image of the operating settings.
// Assumes nv_resetn models first power-up only; aresetn leaves it alone.
`timescale 1ns/100ps
`default_nettype none
module settings_store
	import run_ctl_pkg::*;
(
	input  wire logic aclk,
	input  wire logic nv_resetn,
	nv_if.store       nv
);
	settings_s image;
	logic      valid;

	// ==========================================================
	// Stored image; erase wins over save
	always_ff @(posedge aclk) begin
		if (!nv_resetn) begin
			image <= SETTINGS_DEFAULT;
			valid <= 1'b0;
		end else if (nv.erase) begin
			image <= SETTINGS_DEFAULT;
			valid <= 1'b0;
		end else if (nv.save) begin
			image <= nv.wr_image;
			valid <= 1'b1;
		end
	end

	assign nv.rd_image = image;
	assign nv.rd_valid = valid;
endmodule
`default_nettype wire

// ---- verification/datapath_model.sv ----
// ============================================================
// Datapath stand-in: answers each cycle start with a done pulse.
// Assumes the bench holds lat at one or more.
`timescale 1ns/100ps
`default_nettype none
module datapath_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       cycle_start,
	input  wire logic [7:0] lat,
	output var  logic       cycle_done
);
	logic [7:0] cnt;

	// Count down from each start, then pulse done for one cycle
	always_ff @(posedge aclk) begin
		cycle_done <= 1'b0;
		if (!aresetn) begin
			cnt <= 8'h00;
		end else if (cnt != 8'h00) begin
			cnt        <= cnt - 8'h01;
			cycle_done <= (cnt == 8'h01);
		end else if (cycle_start) begin
			cnt <= lat;
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// ============================================================
// Self-checking bench for the run control block over AXI4-Lite.
// Assumes the datapath model answers every cycle start.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import run_ctl_pkg::*;
	localparam int T = 10;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, lat;
	logic [31:0] s_axi_wdata, s_axi_rdata, param_out, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, run_stop_pin, keypad_valid;
	logic [15:0] keypad_cmd;
	logic        aclk, aresetn, nv_resetn, cycle_start, cycle_done;
	logic        running, factory_mode;
	int          n_fail, checked, cyc, n_starts, last_start, b, t0;
	int          cnts[3] = '{0, 3, 255};
	int          exps[3] = '{1, 3, 255};

	operating_mode_run_control #(.TICK_CYCLES_P(T)) u_dut (
		.aclk, .aresetn, .nv_resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_stop_pin,
		.keypad_valid, .keypad_cmd, .cycle_start, .cycle_done,
		.running, .factory_mode, .param_out
	);
	datapath_model u_dp (
		.aclk, .aresetn, .cycle_start, .lat, .cycle_done
	);

	// Clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Cycle monitor and hang limit
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cycle_start === 1'b1) begin
			n_starts   <= n_starts + 1;
			last_start <= cyc;
		end
		if (cyc == 30000) begin
			n_fail = n_fail + 1;
			give_verdict;
		end
	end

	// ============================================================
	// Shared tasks
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Write: both halves offered, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ah, wh, bh;
		bh = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!bh) begin
			#1;
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid && s_axi_bready;
			r  = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		logic ah, rh;
		rh = 1'b0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!rh) begin
			#1;
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid && s_axi_rready;
			d  = s_axi_rdata;
			r  = s_axi_rresp;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	task automatic cmd(input logic [31:0] v);
		wr(OFS_CMD, v);
	endtask

	task automatic settle;
		repeat (4) @(posedge aclk);
		#1;
	endtask

	task automatic setpin(input logic v);
		@(posedge aclk);
		run_stop_pin <= v;
		settle;
	endtask

	task automatic wait_starts(input int n);
		for (int i = 0; i < 2000 && n_starts < n; i++) begin
			@(posedge aclk);
			#1;
		end
	endtask

	task automatic do_reset(input logic p, input logic clr);
		@(posedge aclk);
		aresetn      <= 1'b0;
		nv_resetn    <= !clr;
		run_stop_pin <= p;
		repeat (12) @(posedge aclk);
		aresetn   <= 1'b1;
		nv_resetn <= 1'b1;
		settle;
	endtask

	// ============================================================
	// Test sequence
	initial begin
		{aresetn, nv_resetn, keypad_valid, keypad_cmd} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, n_fail, checked, cyc, n_starts, last_start} = '0;
		s_axi_wstrb  = 4'hf;
		run_stop_pin = 1'b1;
		lat          = 8'h02;
		do_reset(1'b1, 1'b1);
		check("factory after boot", factory_mode, 0);
		check("running after boot", running, 0);
		repeat (40) @(posedge aclk);
		check("idle cycles", n_starts, 0);
		rd(OFS_PARAM);
		check("param reset", d, PARAM_RESET);
		rd(OFS_DELAY);
		check("delay reset", d, 32'(DELAY_RESET));
		rd(8'h40);
		check("unmapped read", r, RESP_SLVERR);
		wr(8'h40, 32'h0000_0001);
		check("unmapped write", r, RESP_SLVERR);
		$display("test boot done");
		wr(OFS_PARAM, 32'hcafe_0123);
		wr(OFS_DELAY, 32'h0000_0002);
		cmd(32'h1 << CMD_SAVE);
		wr(OFS_PARAM, 32'h0000_00ff);
		cmd(32'h1 << CMD_LOAD);
		settle;
		check("param after load", param_out, 32'hcafe_0123);
		$display("test save done");
		b = n_starts;
		cmd(32'h1 << CMD_RUN);
		repeat (15) @(posedge aclk);
		cmd(32'h1 << CMD_RUN);
		t0 = cyc;
		wait_starts(b + 1);
		check("start delay", (last_start - t0 >= 2 * T - 3)
			&& (last_start - t0 <= 2 * T + 6), 1);
		wait_starts(b + 4);
		check("repeat cycles", n_starts >= b + 4, 1);
		wr(OFS_PARAM, 32'h0000_7e57);
		settle;
		check("param while running", param_out, 32'h0000_7e57);
		@(posedge aclk);
		keypad_cmd   <= 16'h1 << CMD_STOP;
		keypad_valid <= 1'b1;
		@(posedge aclk);
		keypad_valid <= 1'b0;
		repeat (10) @(posedge aclk);
		b = n_starts;
		repeat (40) @(posedge aclk);
		check("cycles after stop", n_starts, b);
		$display("test run done");
		wr(OFS_DELAY, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			b = n_starts;
			cmd((32'h1 << CMD_SEND) | (32'(cnts[i]) << CMD_COUNT_LSB));
			wait_starts(b + exps[i]);
			repeat (30) @(posedge aclk);
			check("burst cycles", n_starts - b, exps[i]);
			check("state after burst", running, 0);
		end
		lat <= 8'h1e;
		b = n_starts;
		cmd((32'h1 << CMD_SEND) | (32'h2 << CMD_COUNT_LSB));
		cmd(32'h1 << CMD_RUN);
		#1;
		check("run held in burst", running, 0);
		wait_starts(b + 2);
		repeat (40) @(posedge aclk);
		settle;
		check("run after burst", running, 1);
		cmd((32'h1 << CMD_SEND) | (32'h2 << CMD_COUNT_LSB));
		repeat (200) @(posedge aclk);
		check("run kept by burst", running, 1);
		lat <= 8'h02;
		cmd(32'h1 << CMD_STOP);
		$display("test send done");
		// Lap and count functions are never active here
		cmd(32'h1 << CMD_PIN_EN);
		settle;
		check("pin high runs", running, 1);
		setpin(1'b0);
		check("pin low stops", running, 0);
		setpin(1'b1);
		check("pin rise runs", running, 1);
		cmd(32'h1 << CMD_STOP);
		settle;
		check("stop over pin", running, 0);
		cmd(32'h1 << CMD_PIN_DIS);
		setpin(1'b0);
		setpin(1'b1);
		check("pin ignored", running, 0);
		rd(OFS_STATUS);
		check("status idle", d, 32'h1 << STS_PIN);
		$display("test pin done");
		wr(OFS_PARAM, 32'h0bad_f00d);
		cmd(32'h1 << CMD_RESTORE);
		settle;
		check("restore mode", factory_mode, 1);
		check("restore param", param_out, PARAM_RESET);
		wr(OFS_PARAM, 32'h5a5a_0001);
		cmd(32'h1 << CMD_SAVE);
		do_reset(1'b1, 1'b0);
		check("boot saved mode", factory_mode, 0);
		check("boot saved param", param_out, 32'h5a5a_0001);
		do_reset(1'b0, 1'b0);
		check("boot pin low", factory_mode, 1);
		setpin(1'b1);
		cmd(32'h1 << CMD_LOAD);
		settle;
		check("erased store", param_out, PARAM_RESET);
		$display("test modes done");
		give_verdict;
	end
endmodule
`default_nettype wire
